// >>> design/adc_control_registers.sv
// Register file and conversion sequencing for the 12-bit converter
`timescale 1ns/1ns
module adc_control_registers (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Register port
    input  wire logic [3:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic [7:0]                     reg_rdata,
    // Converter core
    input  wire logic [11:0]               core_result,
    input  wire logic                      lvd_lvr_active,
    output logic                           core_power,
    output logic                           core_sample_clk,
    output logic [11:0]                    ext_channel_onehot,
    output logic [2:0]                     input_source_route,
    output logic [1:0]                     source_divide,
    output logic [2:0]                     reference_route,
    output logic [1:0]                     reference_gain,
    output logic                           gain_amp_on,
    output logic                           bandgap_on,
    output logic                           ext_ref_in_pin_sel,
    output logic                           ref_out_pin_sel,
    // Pin function control
    output logic [11:0]                    analog_inputs,
    output logic [11:0]                    pull_high_block,
    // Interrupt
    output logic                           irq
);
    import adc_ctrl_pkg::*;

    logic [7:0]        conv_control_r;
    logic [7:0]        source_clock_r;
    logic [7:0]        reference_r;
    logic [11:0]       pin_en_r;
    logic [11:0]       result_r;
    logic              busy_r;
    logic [4:0]        conv_cnt_r;
    logic [6:0]        prescale_r;
    logic              conv_tick;
    logic              irq_status_r;
    logic              irq_mask_r;
    logic              done_evt;
    logic              start_seq;
    conv_state_type    state_r;
    logic [7:0]        rdata_nxt;

    function automatic logic wr_hit(input logic [3:0] a);
        return reg_write && (reg_addr == a);
    endfunction

    wire converter_enable   = conv_control_r[BIT_ENABLE];
    wire result_justify_sel = conv_control_r[BIT_JUSTIFY];
    wire [3:0] ext_channel_sel  = conv_control_r[3:0];
    wire [2:0] input_source_sel = source_clock_r[7:5];
    wire [2:0] conv_clock_sel   = source_clock_r[2:0];
    wire gain_amp_enable    = reference_r[BIT_GAIN];
    wire bandgap_enable     = reference_r[BIT_BGAP];
    wire [3:0] reference_sel = reference_r[3:0];

    // Start fires on the falling write of the start bit
    assign start_seq = wr_hit(ADDR_CONV_CONTROL) && conv_control_r[BIT_START]
                       && !reg_wdata[BIT_START] && reg_wdata[BIT_ENABLE];

    always_ff @(posedge clk)
    begin
        if (reset)
            conv_control_r <= RESET_BYTE;
        else if (wr_hit(ADDR_CONV_CONTROL))
            conv_control_r <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            source_clock_r <= RESET_BYTE;
        else if (wr_hit(ADDR_SOURCE_CLOCK))
            source_clock_r <= reg_wdata & SOURCE_CLOCK_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            reference_r <= RESET_BYTE;
        else if (wr_hit(ADDR_REFERENCE))
            reference_r <= reg_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            pin_en_r <= 12'h000;
        else if (wr_hit(ADDR_PIN_EN_LOW))
            pin_en_r[7:0] <= reg_wdata;
        else if (wr_hit(ADDR_PIN_EN_HIGH))
            pin_en_r[11:8] <= reg_wdata[3:0];
    end

    // Conversion clock prescaler, free running
    always_ff @(posedge clk)
    begin
        if (reset)
            prescale_r <= 7'h00;
        else
            prescale_r <= prescale_r + 7'h01;
    end

    assign conv_tick = (conv_clock_sel == 3'h0) ? 1'b1
                     : (prescale_r & 7'((8'h01 << conv_clock_sel) - 8'h01)) == 7'h00;

    // Disabling mid conversion aborts and leaves old result
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r    <= ST_IDLE;
            busy_r     <= 1'b0;
            conv_cnt_r <= 5'h00;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start_seq)
                    begin
                        state_r    <= ST_CONVERT;
                        busy_r     <= 1'b1;
                        conv_cnt_r <= 5'h00;
                    end
                end
                ST_CONVERT:
                begin
                    if (!converter_enable)
                    begin
                        state_r <= ST_IDLE;
                        busy_r  <= 1'b0;
                    end
                    else if (conv_tick)
                    begin
                        if (conv_cnt_r == CONV_CYCLES_M1)
                        begin
                            state_r <= ST_IDLE;
                            busy_r  <= 1'b0;
                        end
                        else
                            conv_cnt_r <= conv_cnt_r + 5'h01;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                    busy_r  <= 1'b0;
                end
            endcase
        end
    end

    assign done_evt = (state_r == ST_CONVERT) && converter_enable && conv_tick
                      && (conv_cnt_r == CONV_CYCLES_M1);

    always_ff @(posedge clk)
    begin
        if (reset)
            result_r <= 12'h000;
        else if (done_evt)
            result_r <= core_result;
    end

    // Set wins over clear
    always_ff @(posedge clk)
    begin
        if (reset)
            irq_status_r <= 1'b0;
        else if (done_evt)
            irq_status_r <= 1'b1;
        else if (wr_hit(ADDR_IRQ_STATUS) && reg_wdata[0])
            irq_status_r <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq_mask_r <= 1'b0;
        else if (wr_hit(ADDR_IRQ_MASK))
            irq_mask_r <= reg_wdata[0];
    end

    always_comb
    begin
        rdata_nxt = RESET_BYTE;
        case (reg_addr)
            ADDR_RESULT_LOW:
                rdata_nxt = result_justify_sel ? result_r[7:0]
                                               : {result_r[3:0], 4'h0};
            ADDR_RESULT_HIGH:
                rdata_nxt = result_justify_sel ? {4'h0, result_r[11:8]}
                                               : result_r[11:4];
            ADDR_CONV_CONTROL:
                rdata_nxt = {conv_control_r[7], busy_r, conv_control_r[5:0]};
            ADDR_SOURCE_CLOCK:
                rdata_nxt = source_clock_r & SOURCE_CLOCK_MASK;
            ADDR_REFERENCE:
                rdata_nxt = reference_r;
            ADDR_PIN_EN_LOW:
                rdata_nxt = pin_en_r[7:0];
            ADDR_PIN_EN_HIGH:
                rdata_nxt = {4'h0, pin_en_r[11:8]};
            ADDR_IRQ_STATUS:
                rdata_nxt = {7'h00, irq_status_r};
            ADDR_IRQ_MASK:
                rdata_nxt = {7'h00, irq_mask_r};
            default:
                rdata_nxt = RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            reg_rdata <= RESET_BYTE;
        else if (reg_read)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= RESET_BYTE;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= (irq_status_r || done_evt) && irq_mask_r;
    end

    // Analog routing, registered so every output is a flop
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            core_power         <= 1'b0;
            core_sample_clk    <= 1'b0;
            ext_channel_onehot <= 12'h000;
            input_source_route <= 3'h0;
            source_divide      <= 2'h0;
            analog_inputs      <= 12'h000;
            pull_high_block    <= 12'h000;
        end
        else
        begin
            core_power      <= converter_enable;
            core_sample_clk <= conv_tick && busy_r;
            // Internal source forces the external mux open
            if (input_source_sel[1:0] == 2'h0 && ext_channel_sel < NUM_CHANNELS)
                ext_channel_onehot <= 12'(13'h0001 << ext_channel_sel);
            else
                ext_channel_onehot <= 12'h000;
            if (input_source_sel[1:0] == 2'h0)
                input_source_route <= 3'(1 << SRC_EXTERNAL);
            else if (input_source_sel[2])
                input_source_route <= 3'(1 << SRC_REFERENCE);
            else
                input_source_route <= 3'(1 << SRC_SUPPLY);
            source_divide   <= (input_source_sel[1:0] == 2'h0) ? 2'h0
                             : 2'(input_source_sel[1:0] - 2'h1);
            analog_inputs   <= pin_en_r;
            pull_high_block <= pin_en_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reference_route    <= 3'h0;
            reference_gain     <= 2'h0;
            gain_amp_on        <= 1'b0;
            bandgap_on         <= 1'b0;
            ext_ref_in_pin_sel <= 1'b0;
            ref_out_pin_sel    <= 1'b0;
        end
        else
        begin
            gain_amp_on        <= gain_amp_enable;
            bandgap_on         <= bandgap_enable || lvd_lvr_active;
            ext_ref_in_pin_sel <= reference_r[5];
            ref_out_pin_sel    <= reference_r[4];
            if (reference_sel >= 4'h1 && reference_sel <= 4'h4)
            begin
                reference_route <= 3'(1 << REF_EXTERNAL);
                reference_gain  <= 2'(reference_sel - 4'h1);
            end
            else if (reference_sel >= 4'hA && reference_sel <= 4'hC)
            begin
                reference_route <= 3'(1 << REF_BANDGAP);
                reference_gain  <= 2'(reference_sel - 4'h9);
            end
            else if (reference_sel == 4'h9 || (reference_sel >= 4'h5 && reference_sel <= 4'h8))
            begin
                reference_route <= 3'h0;
                reference_gain  <= 2'h0;
            end
            else
            begin
                reference_route <= 3'(1 << REF_SUPPLY);
                reference_gain  <= 2'h0;
            end
        end
    end
endmodule

// >>> pkg/adc_ctrl_pkg.sv
// Constants and types for the converter control register block
//
// Contract
// - Start bit high then low begins conversion
// - Busy flag high during conversion, read-only
// - Enable powers converter; disabled keeps results
// - Justify 0: high=D11..4, low[7:4]=D3..0
// - Justify 1: high[3:0]=D11..8, low=D7..0
// - Unused result bits read as zero
// - Channel codes 0..11 select input; others float
// - Source field picks external, supply or reference
// - Internal source disconnects external channel
// - Clock select divides system clock 1..128
// - Pin enable makes pin analog input only
// - Analog pin drops its pull-high resistor
// - Gain amp enable provides internal reference
// - Bandgap on when enabled or otherwise needed
// - Source register bits 4,3 read zero
// - Reference select maps supply, external, bandgap
package adc_ctrl_pkg;
    localparam logic [3:0] ADDR_RESULT_LOW     = 4'h0;
    localparam logic [3:0] ADDR_RESULT_HIGH    = 4'h1;
    localparam logic [3:0] ADDR_CONV_CONTROL   = 4'h2;
    localparam logic [3:0] ADDR_SOURCE_CLOCK   = 4'h3;
    localparam logic [3:0] ADDR_REFERENCE      = 4'h4;
    localparam logic [3:0] ADDR_PIN_EN_LOW     = 4'h5;
    localparam logic [3:0] ADDR_PIN_EN_HIGH    = 4'h6;
    localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h7;
    localparam logic [3:0] ADDR_IRQ_MASK       = 4'h8;

    localparam int BIT_START   = 7;
    localparam int BIT_BUSY    = 6;
    localparam int BIT_ENABLE  = 5;
    localparam int BIT_JUSTIFY = 4;
    localparam int BIT_GAIN    = 7;
    localparam int BIT_BGAP    = 6;

    localparam logic [7:0] RESET_BYTE          = 8'h00;
    localparam logic [7:0] SOURCE_CLOCK_MASK   = 8'hE7;
    localparam logic [7:0] PIN_EN_HIGH_MASK    = 8'h0F;
    localparam logic [7:0] IRQ_MASK_BITS       = 8'h01;

    localparam int CONV_CYCLES = 16;
    localparam logic [4:0] CONV_CYCLES_M1 = 5'(CONV_CYCLES - 1);
    localparam logic [3:0] NUM_CHANNELS = 4'hC;

    localparam int BGAP_SETTLE_NS = 200;
    localparam int CLK_PERIOD_NS  = 50;
    localparam int BGAP_SETTLE_CYCLES = (BGAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SRC_EXTERNAL,
        SRC_SUPPLY,
        SRC_REFERENCE
    } source_kind_type;

    typedef enum logic [2:0] {
        REF_SUPPLY,
        REF_EXTERNAL,
        REF_BANDGAP,
        REF_RESERVED
    } ref_kind_type;

    typedef enum {
        ST_IDLE,
        ST_CONVERT
    } conv_state_type;
endpackage

// >>> verif/adc_control_registers_chk.sv
// Port-level assertions for the converter control register block
`timescale 1ns/1ns
module adc_control_registers_chk
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    // Converter and pins
    input wire logic        lvd_lvr_active,
    input wire logic        core_power,
    input wire logic        bandgap_on,
    input wire logic [11:0] ext_channel_onehot,
    input wire logic [2:0]  input_source_route,
    input wire logic [2:0]  reference_route,
    input wire logic [11:0] analog_inputs,
    input wire logic [11:0] pull_high_block
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence wr_start;
        reg_write && reg_addr == ADDR_CONV_CONTROL && reg_wdata[BIT_START];
    endsequence
    sequence wr_release;
        reg_write && reg_addr == ADDR_CONV_CONTROL && !reg_wdata[BIT_START]
            && reg_wdata[BIT_ENABLE];
    endsequence
    chk_channel_onehot: assert property ($onehot0(ext_channel_onehot))
        else $error("more than one channel selected");
    chk_internal_off: assert property (|input_source_route[2:1] |-> ext_channel_onehot == 12'h000)
        else $error("external channel kept with internal source");
    chk_route_single: assert property ($onehot0(input_source_route))
        else $error("input source route not one-hot");
    chk_pull_drop: assert property (pull_high_block == analog_inputs)
        else $error("pull-high kept on analog pin");
    chk_ref_single: assert property ($onehot0(reference_route))
        else $error("reference route not one-hot");
    chk_bandgap_keep: assert property (!$past(reset) && $past(lvd_lvr_active) |-> bandgap_on)
        else $error("bandgap off while detector active");
    chk_start_power: assert property (wr_start ##[1:2] wr_release |-> ##[1:2] core_power)
        else $error("converter unpowered after enabled start");
    chk_pin_write: assert property (reg_write && reg_addr == ADDR_PIN_EN_LOW |->
        ##2 analog_inputs[7:0] == $past(reg_wdata, 2))
        else $error("analog pins do not follow write");
endmodule

bind adc_control_registers adc_control_registers_chk adc_control_registers_chk_i (
    .clk, .reset, .reg_addr, .reg_wdata, .reg_write, .lvd_lvr_active, .core_power,
    .bandgap_on, .ext_channel_onehot, .input_source_route, .reference_route,
    .analog_inputs, .pull_high_block);

// >>> verif/tb_top.sv
// Self-checking bench for the converter control register block
`timescale 1ns/1ns
module tb_top;
    import adc_ctrl_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [11:0] core_result = 12'h000;
    logic        lvd_lvr_active = 1'b0;
    logic [7:0]  reg_rdata;
    logic        core_power, core_sample_clk, gain_amp_on, bandgap_on;
    logic        ext_ref_in_pin_sel, ref_out_pin_sel, irq;
    logic [11:0] ext_channel_onehot, analog_inputs, pull_high_block;
    logic [2:0]  input_source_route, reference_route;
    logic [1:0]  source_divide, reference_gain;
    int          num_errors = 0;
    int          checks = 0;
    int          ticks = 0;

    always #25 clk = ~clk;
    // Ticks counted apart so register reads may overlap a conversion
    always @(posedge clk) if (core_sample_clk === 1'b1) ticks <= ticks + 1;

    adc_control_registers adc_control_registers_i (
        .clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .core_result, .lvd_lvr_active, .core_power, .core_sample_clk,
        .ext_channel_onehot, .input_source_route, .source_divide, .reference_route,
        .reference_gain, .gain_amp_on, .bandgap_on, .ext_ref_in_pin_sel,
        .ref_out_pin_sel, .analog_inputs, .pull_high_block, .irq);

    task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [3:0] a, logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rdc(logic [3:0] a, logic [7:0] exp, string name);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check(name, reg_rdata, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    function automatic logic [4:0] src_exp(logic [2:0] s);
        if (s[1:0] == 2'h0) return 5'h04;
        return {s[2] ? 3'h4 : 3'h2, 2'(s[1:0] - 2'h1)};
    endfunction

    function automatic logic [4:0] ref_exp(logic [3:0] r);
        if (r == 4'h0 || r > 4'hC) return 5'h04;
        if (r <= 4'h4) return {3'h2, 2'(r - 4'h1)};
        if (r >= 4'hA) return {3'h4, 2'(r - 4'h9)};
        return 5'h00;
    endfunction

    task automatic t_regs;
        rdc(ADDR_CONV_CONTROL, 8'h00, "conv_control reset");
        wr(ADDR_CONV_CONTROL, 8'h5F);
        rdc(ADDR_CONV_CONTROL, 8'h1F, "busy write");
        wr(ADDR_SOURCE_CLOCK, 8'hFF);
        rdc(ADDR_SOURCE_CLOCK, 8'hE7, "source_clock_select");
        wr(ADDR_PIN_EN_LOW, 8'hA5);
        wr(ADDR_PIN_EN_HIGH, 8'hFF);
        rdc(ADDR_PIN_EN_HIGH, 8'h0F, "analog_pin_enable_high");
        settle();
        check("analog_inputs", analog_inputs, 12'hFA5);
        check("pull_high_block", pull_high_block, 12'hFA5);
        wr(ADDR_RESULT_LOW, 8'hFF);
        rdc(ADDR_RESULT_LOW, 8'h00, "result write");
        rdc(4'hF, 8'h00, "unmapped");
    endtask

    task automatic t_routes;
        for (int c = 0; c < 16; c++)
        begin
            wr(ADDR_SOURCE_CLOCK, 8'h00);
            wr(ADDR_CONV_CONTROL, 8'(c));
            settle();
            check("channel", ext_channel_onehot, c < 12 ? 12'h001 << c : 12'h000);
        end
        for (int s = 0; s < 8; s++)
        begin
            wr(ADDR_SOURCE_CLOCK, {3'(s), 5'h00});
            wr(ADDR_CONV_CONTROL, 8'h05);
            settle();
            check("source", {input_source_route, source_divide}, src_exp(3'(s)));
            check("ext off", ext_channel_onehot, s[1:0] == 0 ? 12'h020 : 12'h000);
        end
        for (int r = 0; r < 16; r++)
        begin
            wr(ADDR_REFERENCE, {4'hF, 4'(r)});
            settle();
            check("reference", {reference_route, reference_gain}, ref_exp(4'(r)));
        end
        check("ref bits", {gain_amp_on, bandgap_on, ext_ref_in_pin_sel, ref_out_pin_sel},
            12'h00F);
        wr(ADDR_REFERENCE, 8'h00);
        lvd_lvr_active <= 1'b1;
        settle();
        check("bandgap lvd", bandgap_on, 12'h001);
        lvd_lvr_active <= 1'b0;
        settle();
        check("bandgap off", {gain_amp_on, bandgap_on}, 12'h000);
    endtask

    task automatic t_convert(logic [2:0] sel, logic [7:0] just, logic [11:0] r);
        int n;
        int t0;
        n = 0;
        core_result <= r;
        wr(ADDR_SOURCE_CLOCK, {5'h00, sel});
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_REFERENCE, 8'h40);
        // Bandgap needs its settle time before a start
        repeat (BGAP_SETTLE_CYCLES) @(posedge clk);
        wr(ADDR_CONV_CONTROL, 8'hA0 | just);
        // Base taken here so the tick counter keeps one driver
        #1 t0 = ticks;
        wr(ADDR_CONV_CONTROL, 8'h20 | just);
        rdc(ADDR_CONV_CONTROL, 8'h60 | just, "busy set");
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            #1 n++;
        end
        n = n + 3;
        check("span ok", 12'(n >= (CONV_CYCLES - 1) << sel &&
            n <= (CONV_CYCLES + 1 << sel) + 8), 12'h001);
        rdc(ADDR_CONV_CONTROL, 8'h20 | just, "busy clear");
        // Last tick pulse is only counted one edge after the interrupt
        check("ticks", 12'(ticks - t0), 12'(CONV_CYCLES));
        rdc(ADDR_RESULT_HIGH, just[4] ? {4'h0, r[11:8]} : r[11:4], "high");
        rdc(ADDR_RESULT_LOW, just[4] ? r[7:0] : {r[3:0], 4'h0}, "low");
        rdc(ADDR_IRQ_STATUS, 8'h01, "irq_status");
        wr(ADDR_IRQ_STATUS, 8'h01);
        settle();
        check("irq clear", irq, 12'h000);
    endtask

    task automatic t_disabled;
        wr(ADDR_CONV_CONTROL, 8'h10);
        core_result <= 12'h123;
        wr(ADDR_CONV_CONTROL, 8'h90);
        wr(ADDR_CONV_CONTROL, 8'h10);
        repeat (40) @(posedge clk);
        rdc(ADDR_CONV_CONTROL, 8'h10, "disabled start");
        // Slow clock so the disable lands mid conversion
        wr(ADDR_SOURCE_CLOCK, 8'h07);
        wr(ADDR_CONV_CONTROL, 8'hB0);
        wr(ADDR_CONV_CONTROL, 8'h30);
        rdc(ADDR_CONV_CONTROL, 8'h70, "abort busy");
        wr(ADDR_CONV_CONTROL, 8'h10);
        rdc(ADDR_CONV_CONTROL, 8'h10, "abort idle");
        rdc(ADDR_IRQ_STATUS, 8'h00, "abort irq");
        check("core_power off", core_power, 12'h000);
        rdc(ADDR_RESULT_HIGH, 8'h05, "kept high");
        rdc(ADDR_RESULT_LOW, 8'hE3, "kept low");
    endtask

    task automatic stop_test;
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #2000000;
        num_errors++;
        stop_test();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_routes();
        t_convert(3'h0, 8'h00, 12'hABC);
        t_convert(3'h3, 8'h10, 12'h5E3);
        t_disabled();
        stop_test();
    end
endmodule
